//--- hdl/tmr2_timer.sv
// Purpose: 16-bit prescaled timer with modulo limit and two capture/compare channels.
// Assumes: APB slave, zero wait states; debug break comes from logic on pclk.
// Notes:   8-bit registers in bits 7:0 of aligned words; upper bits read zero.
`timescale 1ns/100ps
module tmr2_timer (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire tmr2_pkg::tmr2_apb_req_t apb_req,
	output wire tmr2_pkg::tmr2_apb_rsp_t apb_rsp,
	input  wire logic                    dbg_break,
	input  wire logic [1:0]              chan_pin_in,
	output wire logic [1:0]              chan_pin_out,
	output wire logic [1:0]              chan_pin_oe,
	output wire logic                    ovf_irq,
	output wire logic [1:0]              chan_irq
);
	import tmr2_pkg::*;

	typedef struct packed {
		logic [15:0]            cnt;
		logic [5:0]             pre;
		logic                   cnt_new;
		logic                   ovf_flag;
		logic                   ovf_arm;
		logic                   ovf_ie;
		logic                   halt;
		logic [2:0]             ps;
		logic [7:0]             lo_buf;
		logic                   lo_held;
		logic [15:0]            limit;
		logic                   lim_hold;
		tmr2_chctl_t [1:0]      cctl;
		logic [1:0]             carm;
		logic [1:0][15:0]       cval;
		logic [1:0]             cap_blk;
		logic [1:0]             cmp_blk;
		logic                   act_sel;
		logic                   last_wr;
		logic [31:0]            rdata;
	} tmr2_st_t;

	tmr2_st_t         st_ff;
	tmr2_st_t         nxt_st;
	logic [1:0]       pin_s;
	logic             setup_rd;
	logic             wr;
	logic [7:0]       wd;
	logic [7:0]       rd_val;
	logic             hit;
	logic             link;
	logic             run;
	logic [6:0]       mask7;
	logic [5:0]       mask;
	logic             tick;
	logic             ovf;
	logic             ovf_set;
	logic [1:0]       ch_en;
	logic [1:0][15:0] cmp_val_w;
	logic [1:0]       cmp_blk_w;
	logic [1:0]       ch_evt;
	logic [1:0]       ch_cap;

	assign setup_rd = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
	assign wr       = apb_req.psel & apb_req.penable & apb_req.pwrite;
	assign wd       = apb_req.pwdata[7:0];
	assign link     = st_ff.cctl[0].msb;

	assign run   = ~st_ff.halt & ~dbg_break;
	assign mask7 = (7'h01 << st_ff.ps) - 7'h01;
	assign mask  = mask7[5:0];
	assign tick  = run & (st_ff.ps != PS_NONE) & ((st_ff.pre & mask) == mask);
	// Overflow is seen once, in the cycle after the counter takes the limit value
	assign ovf     = st_ff.cnt_new & (st_ff.cnt == st_ff.limit);
	assign ovf_set = ovf & ~st_ff.lim_hold;

	tmr2_sync #(
		.W (2)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (chan_pin_in),
		.q       (pin_s)
	);

	// Channel 0 drives the linked pair; channel 1 goes quiet while linked
	assign ch_en = {~link, 1'b1};
	assign cmp_val_w[0] = (link & st_ff.act_sel) ? st_ff.cval[1] : st_ff.cval[0];
	assign cmp_blk_w[0] = (link & st_ff.act_sel) ? st_ff.cmp_blk[1] : st_ff.cmp_blk[0];
	assign cmp_val_w[1] = st_ff.cval[1];
	assign cmp_blk_w[1] = st_ff.cmp_blk[1];

	for (genvar gi = 0; gi < 2; gi++) begin : g_chan
		tmr2_chan u_chan (
			.pclk    (pclk),
			.presetn (presetn),
			.ctl     (st_ff.cctl[gi]),
			.enable  (ch_en[gi]),
			.cnt     (st_ff.cnt),
			.cnt_new (st_ff.cnt_new),
			.ovf     (ovf),
			.cmp_val (cmp_val_w[gi]),
			.cmp_blk (cmp_blk_w[gi]),
			.cap_blk (st_ff.cap_blk[gi]),
			.pin_s   (pin_s[gi]),
			.evt     (ch_evt[gi]),
			.capture (ch_cap[gi]),
			.pin_out (chan_pin_out[gi]),
			.pin_oe  (chan_pin_oe[gi])
		);
	end

	// Read data and address decode, evaluated in the setup cycle
	always_comb begin
		rd_val = 8'h00;
		hit    = 1'b1;
		case (apb_req.paddr)
			OFS_CTRL:      rd_val = {st_ff.ovf_flag, st_ff.ovf_ie, st_ff.halt, 1'b0,
			                         1'b0, st_ff.ps};
			OFS_CNT_HI:    rd_val = st_ff.cnt[15:8];
			OFS_CNT_LO:    rd_val = st_ff.lo_held ? st_ff.lo_buf : st_ff.cnt[7:0];
			OFS_LIM_HI:    rd_val = st_ff.limit[15:8];
			OFS_LIM_LO:    rd_val = st_ff.limit[7:0];
			OFS_CH_CTL[0]: rd_val = st_ff.cctl[0];
			OFS_CH_HI[0]:  rd_val = st_ff.cval[0][15:8];
			OFS_CH_LO[0]:  rd_val = st_ff.cval[0][7:0];
			OFS_CH_CTL[1]: rd_val = link ? 8'h00 : st_ff.cctl[1];
			OFS_CH_HI[1]:  rd_val = st_ff.cval[1][15:8];
			OFS_CH_LO[1]:  rd_val = st_ff.cval[1][7:0];
			default:       hit    = 1'b0;
		endcase
	end

	always_comb begin
		nxt_st         = st_ff;
		nxt_st.cnt_new = tick;

		// Prescaler and counter
		if (run) begin
			nxt_st.pre = st_ff.pre + 6'h01;
		end
		if (tick) begin
			if (st_ff.cnt == st_ff.limit) begin
				nxt_st.cnt = RST_CNT;
			end else begin
				nxt_st.cnt = st_ff.cnt + 16'h0001;
			end
		end

		// Read side effects happen once, in the setup cycle
		if (setup_rd) begin
			nxt_st.rdata = {24'h000000, rd_val};
			if (apb_req.paddr == OFS_CTRL && st_ff.ovf_flag) begin
				nxt_st.ovf_arm = 1'b1;
			end
			if (apb_req.paddr == OFS_CNT_HI && !st_ff.lo_held) begin
				nxt_st.lo_buf  = st_ff.cnt[7:0];
				nxt_st.lo_held = 1'b1;
			end
			if (apb_req.paddr == OFS_CNT_LO) begin
				nxt_st.lo_held = 1'b0;
			end
			for (int i = 0; i < 2; i++) begin
				if (apb_req.paddr == OFS_CH_CTL[i] && st_ff.cctl[i].flag) begin
					nxt_st.carm[i] = 1'b1;
				end
				if (apb_req.paddr == OFS_CH_HI[i] && !st_ff.cctl[i].msb
				    && !st_ff.cctl[i].msa) begin
					nxt_st.cap_blk[i] = 1'b1;
				end
				if (apb_req.paddr == OFS_CH_LO[i]) begin
					nxt_st.cap_blk[i] = 1'b0;
				end
			end
		end else if (!apb_req.psel) begin
			nxt_st.rdata = 32'h00000000;
		end

		// Writes take effect at the access edge
		if (wr) begin
			case (apb_req.paddr)
				OFS_CTRL: begin
					nxt_st.ovf_ie = wd[CTL_IE_BIT];
					nxt_st.halt   = wd[CTL_HALT_BIT];
					nxt_st.ps     = wd[CTL_PS_LSB +: 3];
					if (!wd[CTL_FLAG_BIT] && st_ff.ovf_arm) begin
						nxt_st.ovf_flag = 1'b0;
					end
					nxt_st.ovf_arm = 1'b0;
					if (wd[CTL_RST_BIT]) begin
						// Also wins over a tick in this cycle
						nxt_st.cnt     = RST_CNT;
						nxt_st.pre     = RST_PRE;
						nxt_st.cnt_new = 1'b0;
					end
				end
				OFS_LIM_HI: begin
					nxt_st.limit[15:8] = wd;
					nxt_st.lim_hold    = 1'b1;
				end
				OFS_LIM_LO: begin
					nxt_st.limit[7:0] = wd;
					nxt_st.lim_hold   = 1'b0;
				end
				default: begin
				end
			endcase
			for (int i = 0; i < 2; i++) begin
				if (apb_req.paddr == OFS_CH_CTL[i] && (i == 0 || !link)) begin
					nxt_st.cctl[i]      = wd;
					nxt_st.cctl[i].flag = st_ff.cctl[i].flag;
					if (i == 1) begin
						nxt_st.cctl[i].msb = 1'b0;
					end
					if (!wd[CTL_FLAG_BIT] && st_ff.carm[i]) begin
						nxt_st.cctl[i].flag = 1'b0;
					end
					nxt_st.carm[i] = 1'b0;
				end
				if (apb_req.paddr == OFS_CH_HI[i]) begin
					nxt_st.cval[i][15:8] = wd;
					if (st_ff.cctl[i].msb || st_ff.cctl[i].msa
					    || (i == 1 && link)) begin
						nxt_st.cmp_blk[i] = 1'b1;
					end
				end
				if (apb_req.paddr == OFS_CH_LO[i]) begin
					nxt_st.cval[i][7:0] = wd;
					nxt_st.cmp_blk[i]   = 1'b0;
					nxt_st.last_wr      = (i == 1);
				end
			end
		end

		// Hardware events: set wins over a clear in the same cycle
		if (ovf_set) begin
			nxt_st.ovf_flag = 1'b1;
			nxt_st.ovf_arm  = 1'b0;
		end
		if (!link) begin
			nxt_st.act_sel = 1'b0;
		end else if (ovf) begin
			nxt_st.act_sel = st_ff.last_wr;
		end
		for (int i = 0; i < 2; i++) begin
			if (ch_cap[i]) begin
				nxt_st.cval[i] = st_ff.cnt;
			end
			if (ch_evt[i]) begin
				nxt_st.cctl[i].flag = 1'b1;
				nxt_st.carm[i]      = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff          <= '0;
			st_ff.cnt      <= RST_CNT;
			st_ff.pre      <= RST_PRE;
			st_ff.halt     <= RST_HALT;
			st_ff.ps       <= RST_PS;
			st_ff.limit    <= RST_LIMIT;
			st_ff.cctl[0]  <= RST_CHCTL;
			st_ff.cctl[1]  <= RST_CHCTL;
			st_ff.cval[0]  <= RST_CHVAL;
			st_ff.cval[1]  <= RST_CHVAL;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign apb_rsp.prdata  = st_ff.rdata;
	assign apb_rsp.pready  = 1'b1;
	// Unmapped addresses answer with an error and read zero
	assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~hit;

	assign ovf_irq     = st_ff.ovf_flag & st_ff.ovf_ie;
	assign chan_irq[0] = st_ff.cctl[0].flag & st_ff.cctl[0].ie;
	assign chan_irq[1] = st_ff.cctl[1].flag & st_ff.cctl[1].ie & ~link;
endmodule : tmr2_timer

//--- hdl/tmr2_pkg.sv
// Purpose: Shared constants and carrier types for the two-channel timer.
// Assumes: APB slave with 32-bit data; each 8-bit register sits in bits 7:0 of one word.
// Notes:   Register offsets are byte addresses.
package tmr2_pkg;
	localparam logic [7:0] OFS_CTRL              = 8'h00;
	localparam logic [7:0] OFS_CNT_HI            = 8'h04;
	localparam logic [7:0] OFS_CNT_LO            = 8'h08;
	localparam logic [7:0] OFS_LIM_HI            = 8'h0C;
	localparam logic [7:0] OFS_LIM_LO            = 8'h10;
	localparam logic [7:0] OFS_CH_CTL [2]        = '{8'h14, 8'h20};
	localparam logic [7:0] OFS_CH_HI [2]         = '{8'h18, 8'h24};
	localparam logic [7:0] OFS_CH_LO [2]         = '{8'h1C, 8'h28};

	// Timer control register bit positions
	localparam int         CTL_FLAG_BIT          = 7;
	localparam int         CTL_IE_BIT            = 6;
	localparam int         CTL_HALT_BIT          = 5;
	localparam int         CTL_RST_BIT           = 4;
	localparam int         CTL_PS_LSB            = 0;
	localparam logic [2:0] PS_NONE               = 3'h7;

	// Values after reset
	localparam logic [15:0] RST_CNT              = 16'h0000;
	localparam logic [15:0] RST_LIMIT            = 16'hFFFF;
	localparam logic        RST_HALT             = 1'b1;
	localparam logic [2:0]  RST_PS               = 3'h0;
	localparam logic [15:0] RST_CHVAL            = 16'h0000;
	localparam logic [7:0]  RST_CHCTL            = 8'h00;
	localparam logic [5:0]  RST_PRE              = 6'h00;

	// Channel control register, bit 7 down to bit 0
	typedef struct packed {
		logic flag;
		logic ie;
		logic msb;
		logic msa;
		logic elsb;
		logic elsa;
		logic tov;
		logic maxd;
	} tmr2_chctl_t;

	// Per-channel pin and output state
	typedef struct packed {
		logic pin_prev;
		logic out_lvl;
		logic max_act;
	} tmr2_chst_t;

	typedef struct packed {
		logic [7:0]  paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} tmr2_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} tmr2_apb_rsp_t;
endpackage : tmr2_pkg

//--- hdl/tmr2_sync.sv
// Purpose: Two-stage synchroniser for the channel pins.
// Assumes: Inputs are asynchronous to pclk.
// Notes:   Only the second stage leaves this module.
`timescale 1ns/100ps
module tmr2_sync #(
	parameter int W = 2
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output wire logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} tmr2_sync_st_t;

	tmr2_sync_st_t st_ff;
	tmr2_sync_st_t nxt_st;

	always_comb begin
		nxt_st    = st_ff;
		nxt_st.s1 = d;
		nxt_st.s2 = st_ff.s1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign q = st_ff.s2;
endmodule : tmr2_sync

//--- hdl/tmr2_chan.sv
// Purpose: Capture edge detection and compare output logic of one channel.
// Assumes: pin_s is already synchronised; cnt_new marks a fresh counter value.
// Notes:   The register file owns the flag and value; this module only reports events.
`timescale 1ns/100ps
module tmr2_chan (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire tmr2_pkg::tmr2_chctl_t ctl,
	input  wire logic               enable,
	input  wire logic [15:0]        cnt,
	input  wire logic               cnt_new,
	input  wire logic               ovf,
	input  wire logic [15:0]        cmp_val,
	input  wire logic               cmp_blk,
	input  wire logic               cap_blk,
	input  wire logic               pin_s,
	output wire logic               evt,
	output wire logic               capture,
	output wire logic               pin_out,
	output wire logic               pin_oe
);
	import tmr2_pkg::*;

	tmr2_chst_t st_ff;
	tmr2_chst_t nxt_st;
	logic       els_on;
	logic       cap_mode;
	logic       out_mode;
	logic       edge_hit;
	logic       match;
	logic       ovf_act;

	assign els_on   = ctl.elsb | ctl.elsa;
	assign cap_mode = enable & ~ctl.msb & ~ctl.msa & els_on;
	assign out_mode = enable & (ctl.msb | ctl.msa) & els_on;
	assign edge_hit = (ctl.elsa & pin_s & ~st_ff.pin_prev)
	                | (ctl.elsb & ~pin_s & st_ff.pin_prev);
	assign capture  = cap_mode & edge_hit & ~cap_blk;
	assign match    = out_mode & cnt_new & (cnt == cmp_val) & ~cmp_blk;
	assign ovf_act  = out_mode & ovf & ctl.tov;
	assign evt      = capture | match;

	always_comb begin
		nxt_st          = st_ff;
		nxt_st.pin_prev = pin_s;
		if (out_mode && ovf) begin
			nxt_st.max_act = ctl.maxd & ctl.tov;
		end
		if (enable && !els_on) begin
			nxt_st.out_lvl = ~ctl.msa;
		end else if (ovf_act) begin
			// Overflow wins over a coincident compare
			if (nxt_st.max_act && ctl.elsb) begin
				nxt_st.out_lvl = ~ctl.elsa;
			end else begin
				nxt_st.out_lvl = ~st_ff.out_lvl;
			end
		end else if (match && !st_ff.max_act) begin
			case ({ctl.elsb, ctl.elsa})
				2'h1:    nxt_st.out_lvl = ~st_ff.out_lvl;
				2'h2:    nxt_st.out_lvl = 1'b0;
				2'h3:    nxt_st.out_lvl = 1'b1;
				default: nxt_st.out_lvl = st_ff.out_lvl;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign pin_out = st_ff.out_lvl;
	assign pin_oe  = out_mode;
endmodule : tmr2_chan

//--- tb/tmr2_sva.sv
// Purpose: Port-level assertions for the two-channel timer.
// Assumes: Zero-wait APB; read data is registered at the setup edge.
// Notes:   A read shows setup-cycle state, so outputs are compared via $past.
`timescale 1ns/100ps
module tmr2_sva (
	input wire logic                    pclk,
	input wire logic                    presetn,
	input wire tmr2_pkg::tmr2_apb_req_t apb_req,
	input wire tmr2_pkg::tmr2_apb_rsp_t apb_rsp,
	input wire logic                    dbg_break,
	input wire logic [1:0]              chan_pin_in,
	input wire logic [1:0]              chan_pin_out,
	input wire logic [1:0]              chan_pin_oe,
	input wire logic                    ovf_irq,
	input wire logic [1:0]              chan_irq
);
	import tmr2_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic       rd_acc;
	logic [7:0] ad;
	logic [7:0] rd;
	assign rd_acc = apb_req.psel && apb_req.penable && !apb_req.pwrite;
	assign ad = apb_req.paddr;
	assign rd = apb_rsp.prdata[7:0];
	property p_slverr;
		apb_req.psel && apb_req.penable |-> apb_rsp.pready
			&& apb_rsp.pslverr == (ad > 8'h28 || ad[1:0] != 2'h0);
	endproperty
	a_slverr: assert property (p_slverr) else $error("bad ready or slave error");
	property p_hi_zero;
		rd_acc |-> apb_rsp.prdata[31:8] == 24'h0;
	endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("upper read bits not zero");
	property p_idle;
		$fell(apb_req.psel) |=> apb_rsp.prdata == 32'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("read data not cleared");
	property p_wo_zero;
		rd_acc && ad == OFS_CTRL |-> rd[4:3] == 2'h0;
	endproperty
	a_wo_zero: assert property (p_wo_zero) else $error("reset bit read nonzero");
	property p_ovf_irq;
		rd_acc && ad == OFS_CTRL |-> $past(ovf_irq) == (rd[7] && rd[6]);
	endproperty
	a_ovf_irq: assert property (p_ovf_irq) else $error("overflow request wrong");
	property p_ch_irq;
		rd_acc && ad == OFS_CH_CTL[0] |-> $past(chan_irq[0]) == (rd[7] && rd[6]);
	endproperty
	a_ch_irq: assert property (p_ch_irq) else $error("channel request wrong");
	property p_link;
		rd_acc && ad == OFS_CH_CTL[0] && rd[5] |-> !$past(chan_pin_oe[1]) && !$past(chan_irq[1]);
	endproperty
	a_link: assert property (p_link) else $error("linked channel 1 active");
	property p_ch1_bit;
		rd_acc && ad == OFS_CH_CTL[1] |-> !rd[5];
	endproperty
	a_ch1_bit: assert property (p_ch1_bit) else $error("channel 1 link bit set");
	property p_oe;
		rd_acc && ad == OFS_CH_CTL[0]
			|-> $past(chan_pin_oe[0]) == (rd[3:2] != 2'h0 && (rd[4] || rd[5]));
	endproperty
	a_oe: assert property (p_oe) else $error("channel 0 drive wrong");
endmodule : tmr2_sva

bind tmr2_timer tmr2_sva i_sva (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .dbg_break(dbg_break), .chan_pin_in(chan_pin_in),
	.chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe), .ovf_irq(ovf_irq),
	.chan_irq(chan_irq));

//--- tb/tmr2_timer_tb_top.sv
// Purpose: Self-checking bench for the two-channel timer.
// Assumes: Zero-wait APB slave; channel pins driven by the bench.
// Notes:   Counts get a small window, since start and stop land on bus edges.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin bad_count++; \
	$display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module tmr2_timer_tb_top;
	import tmr2_pkg::*;
	typedef struct packed {
		logic       w;
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} tmr2_row_t;
	localparam tmr2_row_t ROWS [16] = '{
		'{1'b0, OFS_CTRL, 8'h00, 8'h20}, '{1'b0, OFS_CNT_HI, 8'h00, 8'h00},
		'{1'b0, OFS_CNT_LO, 8'h00, 8'h00}, '{1'b0, OFS_LIM_HI, 8'h00, 8'hFF},
		'{1'b0, OFS_LIM_LO, 8'h00, 8'hFF}, '{1'b0, OFS_CH_CTL[0], 8'h00, 8'h00},
		'{1'b0, OFS_CH_CTL[1], 8'h00, 8'h00}, '{1'b0, 8'h2C, 8'h00, 8'h00},
		'{1'b1, OFS_LIM_HI, 8'h00, 8'h00}, '{1'b1, OFS_LIM_LO, 8'h09, 8'h00},
		'{1'b0, OFS_LIM_LO, 8'h00, 8'h09}, '{1'b1, OFS_CTRL, 8'h3F, 8'h00},
		'{1'b0, OFS_CTRL, 8'h00, 8'h27}, '{1'b1, OFS_CTRL, 8'h20, 8'h00},
		'{1'b1, OFS_CH_HI[0], 8'h00, 8'h00}, '{1'b1, OFS_CH_LO[0], 8'h04, 8'h00}};
	logic          pclk = 1'b0;
	logic          presetn = 1'b0;
	tmr2_apb_req_t req = '0;
	tmr2_apb_rsp_t rsp;
	logic          dbg_break = 1'b0;
	logic [1:0]    pin_in = 2'h0;
	logic [1:0]    pin_out;
	logic [1:0]    pin_oe;
	logic          ovf_irq;
	logic [1:0]    chan_irq;
	int            bad_count = 0;
	int            comparisons = 0;
	int            n;
	logic [7:0]    rv;
	logic [7:0]    v;
	always #2 pclk = ~pclk;
	tmr2_timer i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.dbg_break(dbg_break), .chan_pin_in(pin_in), .chan_pin_out(pin_out),
		.chan_pin_oe(pin_oe), .ovf_irq(ovf_irq), .chan_irq(chan_irq));
	task automatic complete_run;
		if (bad_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run
	// One full transfer; the trailing edge keeps back-to-back calls from double-driving
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		int k;
		k = 0;
		req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: {24'h0, d}};
		@(posedge pclk);
		req.penable <= 1'b1;
		@(posedge pclk);
		while (rsp.pready !== 1'b1 && k < 50) begin
			k++;
			@(posedge pclk);
		end
		if (k == 50) bad_count++;
		rv = rsp.prdata[7:0];
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer
	initial begin
		#200000;
		bad_count++;
		complete_run();
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 16; i++) begin
			xfer(ROWS[i].w, ROWS[i].a, ROWS[i].d);
			if (!ROWS[i].w) `CHK("reg read", ROWS[i].e, rv)
		end
		xfer(1'b1, OFS_CH_CTL[0], 8'h58);
		xfer(1'b1, OFS_CTRL, 8'h40);
		n = 0;
		while (ovf_irq !== 1'b1 && n < 40) begin
			n++;
			@(posedge pclk);
		end
		`CHK("ovf_irq", 1'b1, ovf_irq)
		`CHK("ch0 out/oe", 3'b101, {chan_irq[0], pin_out[0], pin_oe[0]})
		xfer(1'b1, OFS_CTRL, 8'hE0);
		`CHK("flag kept", 1'b1, ovf_irq)
		xfer(1'b0, OFS_CTRL, 8'h00);
		xfer(1'b1, OFS_CTRL, 8'h60);
		`CHK("flag cleared", 1'b0, ovf_irq)
		xfer(1'b0, OFS_CNT_LO, 8'h00);
		v = rv;
		`CHK("wrapped", 1'b1, v <= 8'h09)
		xfer(1'b0, OFS_CNT_HI, 8'h00);
		xfer(1'b1, OFS_CTRL, 8'h30);
		xfer(1'b0, OFS_CNT_LO, 8'h00);
		`CHK("latched lo", v, rv)
		xfer(1'b0, OFS_CNT_LO, 8'h00);
		`CHK("cleared lo", 8'h00, rv)
		xfer(1'b1, OFS_LIM_HI, 8'hFF);
		xfer(1'b1, OFS_LIM_LO, 8'hFF);
		for (int k = 0; k < 8; k++) begin
			xfer(1'b1, OFS_CTRL, 8'h30 | k[7:0]);
			xfer(1'b1, OFS_CTRL, k[7:0]);
			repeat (32 << k) @(posedge pclk);
			xfer(1'b1, OFS_CTRL, 8'h20 | k[7:0]);
			xfer(1'b0, OFS_CNT_LO, 8'h00);
			`CHK("count", 1'b1, k == 7 ? rv == 8'h0 : rv >= 8'd32 && rv <= 8'd36)
		end
		xfer(1'b1, OFS_CTRL, 8'h30);
		dbg_break <= 1'b1;
		xfer(1'b1, OFS_CTRL, 8'h00);
		repeat (20) @(posedge pclk);
		xfer(1'b0, OFS_CNT_LO, 8'h00);
		`CHK("break count", 8'h00, rv)
		dbg_break <= 1'b0;
		repeat (20) @(posedge pclk);
		xfer(1'b0, OFS_CNT_LO, 8'h00);
		`CHK("resumed", 1'b1, rv != 8'h00)
		for (int c = 1; c < 4; c++) begin
			xfer(1'b1, OFS_CH_CTL[1], 8'h40 | 8'(c << 2));
			xfer(1'b0, OFS_CH_CTL[1], 8'h00);
			xfer(1'b1, OFS_CH_CTL[1], 8'h40 | 8'(c << 2));
			`CHK("ch1 clear", 1'b0, chan_irq[1])
			pin_in[1] <= 1'b1;
			repeat (8) @(posedge pclk);
			`CHK("rise capture", c != 2, chan_irq[1])
			// Clear the flag so the falling edge is judged on its own
			xfer(1'b0, OFS_CH_CTL[1], 8'h00);
			xfer(1'b1, OFS_CH_CTL[1], 8'h40 | 8'(c << 2));
			`CHK("flag reclear", 1'b0, chan_irq[1])
			pin_in[1] <= 1'b0;
			repeat (8) @(posedge pclk);
			`CHK("fall capture", c != 1, chan_irq[1])
		end
		// Held high byte must block captures until the low byte is read
		xfer(1'b0, OFS_CH_CTL[1], 8'h00);
		xfer(1'b1, OFS_CH_CTL[1], 8'h4C);
		xfer(1'b0, OFS_CH_HI[1], 8'h00);
		pin_in[1] <= 1'b1;
		repeat (8) @(posedge pclk);
		`CHK("capture blocked", 1'b0, chan_irq[1])
		xfer(1'b0, OFS_CH_LO[1], 8'h00);
		pin_in[1] <= 1'b0;
		repeat (8) @(posedge pclk);
		`CHK("capture freed", 1'b1, chan_irq[1])
		xfer(1'b1, OFS_CH_CTL[0], 8'h20);
		`CHK("linked irq", 1'b0, chan_irq[1])
		xfer(1'b1, OFS_CH_CTL[1], 8'h00);
		xfer(1'b0, OFS_CH_CTL[1], 8'h00);
		`CHK("ch1 ctl hidden", 8'h00, rv)
		xfer(1'b1, OFS_CH_CTL[0], 8'h00);
		`CHK("unlinked irq", 1'b1, chan_irq[1])
		complete_run();
	end
endmodule : tmr2_timer_tb_top
